// ===== src/sahc_pkg.sv
// sahc_pkg: shared constants and types of the converter host-control block
package sahc_pkg;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int NUM_CH      = 4;
  localparam int DATA_W      = 14;
  localparam int SEL_W       = 4;
  localparam int CLK_MHZ     = 100;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CONV_CLOCKS     = 16;
  localparam int T_CONV_INT_NS   = 2400;
  localparam int INT_TICK_CYCLES =
    (T_CONV_INT_NS * CLK_MHZ) / (1000 * CONV_CLOCKS);
  localparam int T_CONVERSION_START_N_MIN_NS = 35;
  localparam int CONVERSION_START_N_CYCLES   = (T_CONVERSION_START_N_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RD_MIN_NS     = 35;
  localparam int RD_CYCLES       = (T_RD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int T_WR_MIN_NS     = 20;
  localparam int WR_CYCLES       = (T_WR_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int T_EXT_CLK_NS    = 200;
  localparam int EXT_HALF_CYCLES = (T_EXT_CLK_NS * CLK_MHZ) / 2000;

  // ************************************************************
  // controller register map
  // ************************************************************
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  REG_CMD      = 8'h00;
  localparam logic [7:0]  REG_CFG      = 8'h04;
  localparam logic [7:0]  REG_STATUS   = 8'h08;
  localparam logic [7:0]  REG_RESULT   = 8'h0C;
  localparam logic [7:0]  REG_IRQ_STAT = 8'h10;
  localparam logic [7:0]  REG_IRQ_MASK = 8'h14;
  localparam int          CMD_START    = 0;
  localparam int          CMD_WRSEL    = 1;
  localparam int          CMD_READ     = 2;
  localparam int          CMD_SEL_LSB  = 4;
  localparam int          CFG_SW       = 0;
  localparam int          CFG_EXT      = 1;
  localparam int          CFG_INC_LSB  = 4;
  localparam logic [7:0]  CFG_RESET    = 8'hF0;
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_FIRST   = 1;
  localparam int          STAT_OP      = 2;
  localparam int          RES_FIRST    = 15;
  localparam int          IRQ_DONE     = 0;
  localparam int          IRQ_RDDONE   = 1;
  localparam int          IRQ_W        = 2;
  localparam logic [3:0]  SEL_RESET    = 4'hF;

  // ************************************************************
  // state types
  // ************************************************************
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_SEEK = 2'b01,
    DEV_CONV = 2'b11
  } sahc_dev_state_t;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_CONV = 3'b001,
    HST_WR   = 3'b011,
    HST_WEND = 3'b111,
    HST_RD   = 3'b010,
    HST_REND = 3'b110
  } sahc_host_state_t;

endpackage : sahc_pkg

// ===== src/sahc_bus_if.sv
// sahc_bus_if: pins between the converter and its host controller
`timescale 1ns/1ps
interface sahc_bus_if;
  logic                        conversion_start_n;
  logic                        cs_n;
  logic                        rd_n;
  logic                        wr_n;
  logic                        busy;
  logic                        first_result_flag;
  logic                        ext_clk_or_include1;
  logic                        clock_source_or_include2;
  logic                        hw_include_ch3;
  logic                        hw_include_ch4;
  logic                        seq_sw_select;
  logic [sahc_pkg::DATA_W-1:0] host_db_out;
  logic                        host_db_oe;
  logic [sahc_pkg::DATA_W-1:0] dev_db_out;
  logic                        dev_db_oe;
  logic [sahc_pkg::DATA_W-1:0] db;

  // undriven bus reads as zero here
  assign db = dev_db_oe  ? dev_db_out  :
              host_db_oe ? host_db_out : '0;

  modport device (
    input  conversion_start_n, cs_n, rd_n, wr_n,
    input  ext_clk_or_include1, clock_source_or_include2,
    input  hw_include_ch3, hw_include_ch4, seq_sw_select, db,
    output busy, first_result_flag, dev_db_out, dev_db_oe
  );

  modport host (
    output conversion_start_n, cs_n, rd_n, wr_n,
    output ext_clk_or_include1, clock_source_or_include2,
    output hw_include_ch3, hw_include_ch4, seq_sw_select,
    output host_db_out, host_db_oe,
    input  busy, first_result_flag, db
  );
endinterface : sahc_bus_if

// ===== src/sahc_device.sv
// sahc_device: sequencing and parallel-port logic of the converter
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module sahc_device #(
  parameter int TICK_CYCLES = sahc_pkg::INT_TICK_CYCLES
) (
  // clock, reset and enable
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire logic                   ce,
  // converter pins
  sahc_bus_if.device                 pins,
  // digitised front-end levels, channel 1 in the low field
  input wire logic [sahc_pkg::NUM_CH*sahc_pkg::DATA_W-1:0] analog_code
);
  import sahc_pkg::*;

  localparam logic [2:0] CH_END   = 3'(NUM_CH);
  localparam logic [4:0] CONV_TOP = 5'(CONV_CLOCKS - 1);
  localparam logic [7:0] TICK_TOP = 8'(TICK_CYCLES - 1);

  // ************************************************************
  // pin edges
  // ************************************************************
  logic prev_conversion_start_n;
  logic prev_rd;
  logic prev_wr;
  logic prev_xclk;
  logic conv_rise;
  logic rd_rise;
  logic wr_rise;
  logic xclk_rise;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev_conversion_start_n <= 1'b1;
      prev_rd     <= 1'b1;
      prev_wr     <= 1'b1;
      prev_xclk   <= 1'b0;
    end else if (ce) begin
      prev_conversion_start_n <= pins.conversion_start_n;
      prev_rd     <= pins.rd_n;
      prev_wr     <= pins.wr_n;
      prev_xclk   <= pins.ext_clk_or_include1;
    end
  end

  assign conv_rise = pins.conversion_start_n & ~prev_conversion_start_n;
  // a strobe edge counts only while the part is selected
  assign rd_rise   = pins.rd_n & ~prev_rd & ~pins.cs_n;
  assign wr_rise   = pins.wr_n & ~prev_wr & ~pins.cs_n
                   & pins.rd_n;
  assign xclk_rise = pins.ext_clk_or_include1 & ~prev_xclk;

  // ************************************************************
  // channel select register
  // ************************************************************
  logic [SEL_W-1:0] chan_sel;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chan_sel <= SEL_RESET;
    end else if (ce && wr_rise) begin
      chan_sel <= pins.db[SEL_W-1:0];
    end
  end

  // ************************************************************
  // sequence selection and clock source
  // ************************************************************
  logic [SEL_W-1:0] live_sel;
  logic             live_ext;
  logic [SEL_W-1:0] seq_sel;
  logic             ext_mode;
  sahc_dev_state_t  state;
  logic             start_ok;

  // in hardware mode the shared pins are include bits, the
  // conversion clock is internal whatever pin two shows
  assign live_sel = pins.seq_sw_select ? chan_sel :
                    {pins.hw_include_ch4, pins.hw_include_ch3,
                     pins.clock_source_or_include2,
                     pins.ext_clk_or_include1};
  assign live_ext = pins.seq_sw_select
                  & pins.clock_source_or_include2;
  // a start edge during a running sequence is ignored
  assign start_ok = conv_rise && (state == DEV_IDLE);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seq_sel  <= '0;
      ext_mode <= 1'b0;
    end else if (ce && start_ok) begin
      seq_sel  <= live_sel;
      ext_mode <= live_ext;
    end
  end

  // ************************************************************
  // track/hold: all channels frozen by one edge
  // ************************************************************
  logic [DATA_W-1:0] hold   [NUM_CH];
  logic [DATA_W-1:0] result [NUM_CH];
  logic [2:0]        slot;
  logic              conv_done;
  logic [2:0]        ch_idx;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        hold[i] <= '0;
      end else if (ce && start_ok) begin
        hold[i] <= analog_code[i*DATA_W +: DATA_W];
      end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        result[i] <= '0;
      end else if (ce && conv_done && slot == 3'(i)) begin
        result[i] <= hold[ch_idx[1:0]];
      end
    end
  end

  // ************************************************************
  // conversion clock
  // ************************************************************
  logic [7:0] div_cnt;
  logic [4:0] conv_cnt;
  logic       tick;

  // the external clock is sampled on clk_sys, so it must stay
  // well below half the system rate
  assign tick = ext_mode ? xclk_rise
                         : (div_cnt == TICK_TOP);
  assign conv_done = (state == DEV_CONV) && tick
                   && (conv_cnt == CONV_TOP);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt  <= '0;
      conv_cnt <= '0;
    end else if (ce) begin
      if (state != DEV_CONV) begin
        div_cnt  <= '0;
        conv_cnt <= '0;
      end else begin
        div_cnt <= (div_cnt == TICK_TOP) ? '0 : div_cnt + 8'h01;
        if (tick) begin
          conv_cnt <= conv_done ? '0 : conv_cnt + 5'h01;
        end
      end
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  logic busy;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state  <= DEV_IDLE;
      ch_idx <= '0;
    end else if (ce) begin
      case (state)
        DEV_IDLE: begin
          if (start_ok) begin
            state  <= DEV_SEEK;
            ch_idx <= '0;
          end
        end
        DEV_SEEK: begin
          // walk upward to the next included channel
          if (ch_idx == CH_END) begin
            state <= DEV_IDLE;
          end else if (seq_sel[ch_idx[1:0]]) begin
            state <= DEV_CONV;
          end else begin
            ch_idx <= ch_idx + 3'h1;
          end
        end
        DEV_CONV: begin
          if (conv_done) begin
            state  <= DEV_SEEK;
            ch_idx <= ch_idx + 3'h1;
          end
        end
        default: begin
          state <= DEV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else if (ce) begin
      if (start_ok) begin
        busy <= 1'b1;
      end else if (state == DEV_SEEK && ch_idx == CH_END) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slot <= '0;
    end else if (ce) begin
      if (start_ok) begin
        slot <= '0;
      end else if (conv_done) begin
        slot <= slot + 3'h1;
      end
    end
  end

  // ************************************************************
  // output data register pointer and read port
  // ************************************************************
  logic [1:0]        ptr;
  logic [1:0]        next_ptr;
  logic              first_q;
  logic [DATA_W-1:0] db_q;

  always_comb begin
    next_ptr = ptr;
    if (start_ok) begin
      next_ptr = '0;
    end else if (rd_rise) begin
      // wrap over the registers filled so far
      if ({1'b0, ptr} + 3'h1 >= slot) begin
        next_ptr = '0;
      end else begin
        next_ptr = ptr + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ptr     <= '0;
      first_q <= 1'b1;
    end else if (ce) begin
      ptr     <= next_ptr;
      first_q <= (next_ptr == 2'h0);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      db_q <= '0;
    end else if (ce) begin
      db_q <= result[ptr];
    end
  end

  assign pins.busy              = busy;
  assign pins.first_result_flag = first_q;
  assign pins.dev_db_out        = db_q;
  assign pins.dev_db_oe         = ~pins.cs_n & ~pins.rd_n;

endmodule : sahc_device

// ===== src/sahc_host.sv
// sahc_host: register-driven controller that runs the converter pins
`timescale 1ns/1ps
module sahc_host #(
  parameter int CONVERSION_START_N_LOW = sahc_pkg::CONVERSION_START_N_CYCLES,
  parameter int RD_LOW     = sahc_pkg::RD_CYCLES,
  parameter int WR_LOW     = sahc_pkg::WR_CYCLES,
  parameter int EXT_HALF   = sahc_pkg::EXT_HALF_CYCLES
) (
  // clock, reset and enable
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  // converter pins
  sahc_bus_if.host                       pins,
  // software register port
  input  wire logic [sahc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  // interrupt
  output logic                           irq
);
  import sahc_pkg::*;

  // ************************************************************
  // configuration and interrupt registers
  // ************************************************************
  logic [7:0]       cfg;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_set;
  logic [15:0]      result_q;
  logic [SEL_W-1:0] sel_q;
  logic             busy_prev;
  sahc_host_state_t state;
  logic [7:0]       cnt;
  logic             cmd_wr;

  assign cmd_wr = reg_wr && reg_addr == REG_CMD;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg      <= CFG_RESET;
      irq_mask <= '0;
    end else if (ce && reg_wr) begin
      if (reg_addr == REG_CFG) begin
        cfg <= reg_wdata[7:0];
      end
      if (reg_addr == REG_IRQ_MASK) begin
        irq_mask <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_prev <= 1'b0;
      irq_stat  <= '0;
    end else if (ce) begin
      busy_prev <= pins.busy;
      // a new event beats a write-one clear in the same cycle
      if (reg_wr && reg_addr == REG_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~reg_wdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
    end
  end

  assign irq_set[IRQ_DONE]   = busy_prev & ~pins.busy;
  assign irq_set[IRQ_RDDONE] = (state == HST_RD) && cnt == 8'h00;
  assign irq = |(irq_stat & irq_mask);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          REG_CFG:      reg_rdata <= {24'h000000, cfg};
          REG_STATUS:   reg_rdata <= {29'h00000000,
                                      state != HST_IDLE,
                                      pins.first_result_flag,
                                      pins.busy};
          REG_RESULT:   reg_rdata <= {16'h0000, result_q};
          REG_IRQ_STAT: reg_rdata <= {30'h00000000, irq_stat};
          REG_IRQ_MASK: reg_rdata <= {30'h00000000, irq_mask};
          default:      reg_rdata <= '0;
        endcase
      end
    end
  end

  // ************************************************************
  // pin cycle sequencer
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state    <= HST_IDLE;
      cnt      <= '0;
      sel_q    <= '0;
      result_q <= '0;
    end else if (ce) begin
      case (state)
        HST_IDLE: begin
          // commands arriving mid-cycle are dropped
          if (cmd_wr && reg_wdata[CMD_START]) begin
            state <= HST_CONV;
            cnt   <= 8'(CONVERSION_START_N_LOW - 1);
          end else if (cmd_wr && reg_wdata[CMD_WRSEL]) begin
            state <= HST_WR;
            cnt   <= 8'(WR_LOW - 1);
            sel_q <= reg_wdata[CMD_SEL_LSB +: SEL_W];
          end else if (cmd_wr && reg_wdata[CMD_READ]) begin
            state <= HST_RD;
            cnt   <= 8'(RD_LOW - 1);
          end
        end
        HST_CONV: begin
          if (cnt == 8'h00) state <= HST_IDLE;
          else cnt <= cnt - 8'h01;
        end
        HST_WR: begin
          if (cnt == 8'h00) state <= HST_WEND;
          else cnt <= cnt - 8'h01;
        end
        HST_RD: begin
          if (cnt == 8'h00) begin
            state    <= HST_REND;
            result_q <= {pins.first_result_flag, 1'b0, pins.db};
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        HST_WEND: state <= HST_IDLE;
        HST_REND: state <= HST_IDLE;
        default:  state <= HST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // external conversion clock, fifty percent duty
  // ************************************************************
  logic       xclk;
  logic [7:0] xdiv;
  logic       ext_on;

  assign ext_on = cfg[CFG_SW] & cfg[CFG_EXT];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      xclk <= 1'b0;
      xdiv <= '0;
    end else if (ce) begin
      if (!ext_on) begin
        xclk <= 1'b0;
        xdiv <= '0;
      end else if (xdiv == 8'(EXT_HALF - 1)) begin
        xclk <= ~xclk;
        xdiv <= '0;
      end else begin
        xdiv <= xdiv + 8'h01;
      end
    end
  end

  // ************************************************************
  // pin drive
  // ************************************************************
  assign pins.conversion_start_n = state != HST_CONV;
  assign pins.cs_n  = !(state == HST_WR || state == HST_WEND ||
                        state == HST_RD || state == HST_REND);
  // write strobe stays high through every read cycle
  assign pins.wr_n  = state != HST_WR;
  assign pins.rd_n  = state != HST_RD;
  assign pins.host_db_oe  = state == HST_WR || state == HST_WEND;
  assign pins.host_db_out = {{(DATA_W-SEL_W){1'b0}}, sel_q};
  assign pins.seq_sw_select = cfg[CFG_SW];
  assign pins.ext_clk_or_include1 =
    cfg[CFG_SW] ? xclk : cfg[CFG_INC_LSB];
  assign pins.clock_source_or_include2 =
    cfg[CFG_SW] ? cfg[CFG_EXT] : cfg[CFG_INC_LSB+1];
  assign pins.hw_include_ch3 = cfg[CFG_INC_LSB+2];
  assign pins.hw_include_ch4 = cfg[CFG_INC_LSB+3];

endmodule : sahc_host

// ===== testbench/sahc_assertions.sv
// sahc_assertions: pin checks between host controller and converter
`timescale 1ns/1ps
module sahc_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // converter pins
  input wire logic conversion_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic busy,
  input wire logic first_result_flag,
  input wire logic dev_db_oe
);
  // ********************
  // helpers
  // ********************
  logic [2:0] rd_hist;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // the result pointer may only move just after a read or when a start resets it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_hist <= 3'h0;
    end else begin
      rd_hist <= {rd_hist[1:0], !cs_n && !rd_n};
    end
  end

  sequence s_start_rise;
    !conversion_start_n ##1 conversion_start_n;
  endsequence

  property p_busy_start;
    s_start_rise ##0 (!busy && !$past(busy, 2)) |-> ##[1:2] busy [*3];
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy did not follow start");

  property p_busy_cause;
    $rose(busy) |-> $past(conversion_start_n) &&
      (!$past(conversion_start_n, 2) || !$past(conversion_start_n, 3));
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without start");

  property p_busy_ends;
    $rose(busy) |-> ##[1:800] !busy;
  endproperty
  a_busy_ends: assert property (p_busy_ends)
    else $error("busy never fell");

  property p_db_enable;
    dev_db_oe == (!cs_n && !rd_n);
  endproperty
  a_db_enable: assert property (p_db_enable)
    else $error("data enable wrong");

  property p_db_off_write;
    !wr_n |-> !dev_db_oe;
  endproperty
  a_db_off_write: assert property (p_db_off_write)
    else $error("device drove bus during write");

  property p_read_wr_high;
    !cs_n && !rd_n |-> wr_n;
  endproperty
  a_read_wr_high: assert property (p_read_wr_high)
    else $error("write strobe low during read");

  property p_strobe_cs;
    !rd_n || !wr_n |-> !cs_n;
  endproperty
  a_strobe_cs: assert property (p_strobe_cs)
    else $error("strobe without chip select");

  property p_first_moves;
    $changed(first_result_flag) |-> rd_hist != 3'h0 || busy || $past(busy);
  endproperty
  a_first_moves: assert property (p_first_moves)
    else $error("first flag moved without read");
endmodule : sahc_assertions

// ===== testbench/test_simultaneous_adc_host_control.sv
// test_simultaneous_adc_host_control: bench of controller and converter
`timescale 1ns/1ps
module test_simultaneous_adc_host_control;
  import sahc_pkg::*;
  // ********************
  // set-up
  // ********************
  localparam int TICK = 2;
  logic                     clk_sys;
  logic                     rstn;
  logic                     ce;
  logic [ADDR_W-1:0]        reg_addr;
  logic [31:0]              reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [31:0]              reg_rdata;
  logic                     irq;
  logic [NUM_CH*DATA_W-1:0] analog_code;
  logic [31:0]              rd_val;
  int                       failures = 0;
  int                       cmp_count = 0;
  int                       cyc = 0;
  int                       seed = 32'h3B66;

  sahc_bus_if sahc_bus_if_i ();
  sahc_host #(.CONVERSION_START_N_LOW(1), .RD_LOW(2), .WR_LOW(1), .EXT_HALF(2))
    sahc_host_i (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .pins(sahc_bus_if_i), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  sahc_device #(.TICK_CYCLES(TICK)) sahc_device_i (.clk_sys(clk_sys),
    .rstn(rstn), .ce(ce), .pins(sahc_bus_if_i),
    .analog_code(analog_code));
  sahc_assertions sahc_assertions_i (.clk_sys(clk_sys), .rstn(rstn),
    .conversion_start_n(sahc_bus_if_i.conversion_start_n),
    .cs_n(sahc_bus_if_i.cs_n), .rd_n(sahc_bus_if_i.rd_n),
    .wr_n(sahc_bus_if_i.wr_n), .busy(sahc_bus_if_i.busy),
    .first_result_flag(sahc_bus_if_i.first_result_flag),
    .dev_db_oe(sahc_bus_if_i.dev_db_oe));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // a hang ends the run as a failure
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input logic got, input logic exp);
    cmp_reg({31'h0, got}, {31'h0, exp});
  endtask : cmp_pin

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd

  task automatic wait_op();
    rd(REG_STATUS);
    while (rd_val[STAT_OP] !== 1'b0) rd(REG_STATUS);
  endtask : wait_op

  function automatic logic [31:0] exp_result(
    input logic [NUM_CH*DATA_W-1:0] code, input int ch, input logic first);
    exp_result = 32'h0;
    exp_result[DATA_W-1:0] = code[ch*DATA_W +: DATA_W];
    exp_result[RES_FIRST] = first;
  endfunction : exp_result

  // one sequence: start, await done interrupt, read back every result
  task automatic run_seq(input logic [7:0] cfg, input logic [3:0] inc);
    logic [NUM_CH*DATA_W-1:0] held;
    logic [63:0]              r;
    logic                     first;
    int                       k;
    int                       n;
    r = {$random(seed), $random(seed)};
    held = r[NUM_CH*DATA_W-1:0];
    analog_code <= held;
    wr(REG_IRQ_STAT, 32'h3);
    if (cfg[CFG_SW]) wr(REG_CMD, {24'h0, inc, 4'h2});
    wait_op();
    wr(REG_CFG, {24'h0, cfg});
    wr(REG_CMD, 32'h1);
    while (sahc_bus_if_i.busy !== 1'b1) @(posedge clk_sys);
    // inputs move mid-sequence, and in software mode the selection too; held values must win
    analog_code <= ~held;
    if (cfg[CFG_SW]) wr(REG_CMD, {24'h0, ~inc, 4'h2});
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
    cmp_pin(n >= $countones(inc) * CONV_CLOCKS * TICK, 1'b1);
    rd(REG_IRQ_STAT);
    cmp_reg(rd_val, 32'h1);
    first = 1'b1;
    for (k = 0; k < NUM_CH; k++) begin
      if (inc[k]) begin
        wr(REG_CMD, 32'h4);
        wait_op();
        rd(REG_RESULT);
        cmp_reg(rd_val, exp_result(held, k, first));
        first = 1'b0;
      end
    end
    cmp_pin(sahc_bus_if_i.first_result_flag, 1'b1);
  endtask : run_seq

  initial begin
    logic [3:0] inc;
    int         i;
    rstn = 1'b0;
    ce = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    analog_code = '0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(REG_CFG);
    cmp_reg(rd_val, {24'h0, CFG_RESET});
    // a low clock enable must swallow a register write
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(REG_CFG, 32'h0);
    ce <= 1'b1;
    rd(REG_CFG);
    cmp_reg(rd_val, {24'h0, CFG_RESET});
    rd(8'h20);
    cmp_reg(rd_val, 32'h0);
    cmp_pin(sahc_bus_if_i.first_result_flag, 1'b1);
    cmp_pin(sahc_bus_if_i.busy, 1'b0);
    wr(REG_IRQ_MASK, 32'h3);
    // corner selections first, then random ones, in all three modes
    for (i = 0; i < 9; i++) begin
      inc = (i == 0) ? 4'hF : (i == 1) ? 4'h1 : (i == 2) ? 4'h8 :
            4'($random(seed));
      if (inc == 4'h0) inc = 4'h6;
      case (i % 3)
        0: run_seq({inc, 4'h0}, inc);
        1: run_seq({~inc, 4'h1}, inc);
        default: run_seq({~inc, 4'h3}, inc);
      endcase
    end
    wr(REG_IRQ_MASK, 32'h0);
    #1;
    cmp_pin(irq, 1'b0);
    wr(REG_IRQ_MASK, 32'h2);
    #1;
    cmp_pin(irq, 1'b1);
    wr(REG_IRQ_STAT, 32'h2);
    #1;
    cmp_pin(irq, 1'b0);
    rd(REG_IRQ_STAT);
    cmp_reg(rd_val, 32'h1);
    print_verdict();
  end
endmodule : test_simultaneous_adc_host_control
